// >>> debug_hold_pkg.sv
// constants, register map and carrier types of the debug hold unit
// assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus
package debug_hold_pkg;

  // block decode and register offsets
  localparam logic [31:0] BLOCK_BASE_ADDR = 32'h4001_5800;
  localparam int BLOCK_LOW_BITS = 8;
  localparam logic [7:0] OFS_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_CTL_FIRST = 8'h04;
  localparam logic [7:0] OFS_CTL_SECOND = 8'h08;
  localparam logic [7:0] OFS_SWD_SAMPLE = 8'h0c;
  localparam logic [7:0] OFS_SWD_CTRL = 8'h10;

  // debug_control_first fields
  localparam int SLEEP_KEEP_BIT = 0;
  localparam int DEEPSLEEP_KEEP_BIT = 1;
  localparam int STANDBY_KEEP_BIT = 2;
  localparam int FREE_WDG_HOLD_BIT = 8;
  localparam int WINDOW_WDG_HOLD_BIT = 9;
  localparam int TIMER0_HOLD_BIT = 10;
  localparam int TIMER2_HOLD_BIT = 12;
  localparam int I2C0_HOLD_BIT = 15;
  localparam int I2C1_HOLD_BIT = 16;
  localparam int TIMER5_HOLD_BIT = 19;
  localparam int TIMER13_HOLD_BIT = 27;
  localparam logic [31:0] CTL_FIRST_MASK = 32'h0809_9707;

  // debug_control_second fields
  localparam int RTC_HOLD_BIT = 10;
  localparam int TIMER14_HOLD_BIT = 16;
  localparam int TIMER15_HOLD_BIT = 17;
  localparam int TIMER16_HOLD_BIT = 18;
  localparam logic [31:0] CTL_SECOND_MASK = 32'h0007_0400;

  // swd control fields
  localparam int SWD_ENABLE_BIT = 0;
  localparam int SWD_ACTIVE_BIT = 1;

  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic SWD_ENABLE_RESET = 1'b1;

  // ahb-lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // swd activity timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWD_IDLE_TIME_NS = 10000;
  localparam int SWD_IDLE_CYCLES = SWD_IDLE_TIME_NS / CLK_PERIOD_NS;
  localparam int NUM_TIMERS = 7;

  typedef struct packed {
    logic sleep;
    logic deepsleep;
    logic standby;
  } pwr_req_s;

  typedef struct packed {
    logic [NUM_TIMERS-1:0] timer;
    logic [1:0] i2c;
    logic rtc;
    logic window_wdg;
    logic free_wdg;
  } freeze_s;

  typedef enum logic [1:0] {
    PWR_RUN = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_DEEP = 2'h3,
    PWR_STANDBY = 2'h2
  } pwr_state_e;

endpackage : debug_hold_pkg

// >>> debug_sync2.sv
// two-flop synchroniser for levels from outside the core clock domain
// assumes each bit is an independent level; no word coherence
`timescale 1ns/1ns
module debug_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end

endmodule : debug_sync2

// >>> debug_pwr_keep.sv
// power-mode tracker that keeps debug clocks alive in low-power modes
// assumes mode requests are levels from the power controller on core_clk
`timescale 1ns/1ns
module debug_pwr_keep (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire debug_hold_pkg::pwr_req_s pwr_req,
  input wire logic standby_exit,
  input wire logic sleep_debug_keep,
  input wire logic deepsleep_debug_keep,
  input wire logic standby_debug_keep,
  output logic bus_clk_on_osc,
  output logic sys_clk_on_osc,
  output logic cpu_bus_clk_keep,
  output logic sys_reset_req
);

  debug_hold_pkg::pwr_state_e state_q;
  debug_hold_pkg::pwr_state_e state_d;
  logic osc_d;
  logic keep_d;
  logic reset_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      debug_hold_pkg::PWR_RUN: begin
        if (pwr_req.standby) begin
          state_d = debug_hold_pkg::PWR_STANDBY;
        end else if (pwr_req.deepsleep) begin
          state_d = debug_hold_pkg::PWR_DEEP;
        end else if (pwr_req.sleep) begin
          state_d = debug_hold_pkg::PWR_SLEEP;
        end
      end
      debug_hold_pkg::PWR_SLEEP: begin
        if (!pwr_req.sleep) begin
          state_d = debug_hold_pkg::PWR_RUN;
        end
      end
      debug_hold_pkg::PWR_DEEP: begin
        if (!pwr_req.deepsleep) begin
          state_d = debug_hold_pkg::PWR_RUN;
        end
      end
      debug_hold_pkg::PWR_STANDBY: begin
        // standby is only left by its wake event, never by dropping the request
        if (standby_exit) begin
          state_d = debug_hold_pkg::PWR_RUN;
        end
      end
      default: begin
        state_d = debug_hold_pkg::PWR_RUN;
      end
    endcase
    osc_d = ((state_d == debug_hold_pkg::PWR_STANDBY) && standby_debug_keep)
        || ((state_d == debug_hold_pkg::PWR_DEEP) && deepsleep_debug_keep);
    keep_d = (state_d == debug_hold_pkg::PWR_SLEEP) && sleep_debug_keep;
    reset_d = (state_q == debug_hold_pkg::PWR_STANDBY) && standby_exit
        && standby_debug_keep;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= debug_hold_pkg::PWR_RUN;
      bus_clk_on_osc <= 1'b0;
      sys_clk_on_osc <= 1'b0;
      cpu_bus_clk_keep <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      state_q <= state_d;
      bus_clk_on_osc <= osc_d;
      sys_clk_on_osc <= osc_d;
      cpu_bus_clk_keep <= keep_d;
      sys_reset_req <= reset_d;
    end
  end

  chk_standby_osc_src: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == debug_hold_pkg::PWR_RUN && pwr_req.standby && standby_debug_keep)
    |=> (bus_clk_on_osc && sys_clk_on_osc))
    else $error("standby entry with keep did not select oscillator clocks");

  chk_standby_exit_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == debug_hold_pkg::PWR_STANDBY && standby_exit && standby_debug_keep)
    |=> sys_reset_req ##1 !sys_reset_req)
    else $error("standby exit with keep did not pulse system reset");

  chk_deep_osc_src: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == debug_hold_pkg::PWR_RUN && !pwr_req.standby && pwr_req.deepsleep
     && deepsleep_debug_keep) |=> (bus_clk_on_osc && sys_clk_on_osc))
    else $error("deep-sleep entry with keep did not select oscillator clocks");

  chk_sleep_bus_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == debug_hold_pkg::PWR_SLEEP && pwr_req.sleep)
    |=> (cpu_bus_clk_keep == $past(sleep_debug_keep)))
    else $error("sleep bus clock keep does not follow its control bit");

endmodule : debug_pwr_keep

// >>> debug_hold_control.sv
// debug hold unit: ahb-lite register file, peripheral freeze and power-mode clock keep
// assumes one ahb-lite master on core_clk; swd pins arrive asynchronously
//
// Function
// - standby with keep bit runs bus and system clocks from the 8 MHz oscillator.
// - leaving standby with keep bit set raises a full system reset.
// - deep-sleep with keep bit runs bus and system clocks from the oscillator.
// - sleep with keep bit keeps the processor bus clock running.
// - halted core plus timer hold bit freezes that timer counter.
// - halted core plus i2c hold bit freezes that controller's bus timeout.
// - halted core plus rtc hold bit stops the real-time counter.
// - halted core plus watchdog hold bit gates that watchdog's counting clock.
// - identity register reads a fixed word, full word only, writes ignored.
// - block decodes at base 0x4001_5800, identity at offset zero.
// - probe uses a two-pin serial link, data line and probe-driven clock.
// - debug pins can be handed back to general-purpose use when unused.
// - first control register at offset 4, resets to zero on power reset only.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
module debug_hold_control #(
  // arbitrary neutral identity value
  parameter logic [31:0] IDENTITY_VALUE = 32'h0000_5a01
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic core_halted,
  input wire debug_hold_pkg::pwr_req_s pwr_req,
  input wire logic standby_exit,
  input wire logic swclk_pin,
  input wire logic swdio_in,
  output logic swdio_out,
  output logic swdio_oe,
  output logic swd_pins_to_gpio,
  output debug_hold_pkg::freeze_s freeze,
  output logic bus_clk_on_osc,
  output logic sys_clk_on_osc,
  output logic cpu_bus_clk_keep,
  output logic sys_reset_req
);

  // bus slave state
  logic acc;
  logic in_blk;
  logic word_acc;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] wr_ofs_q;
  logic [7:0] wr_ofs_d;
  logic [31:0] hrdata_d;

  // control registers, power-reset domain
  logic [31:0] ctl_first_q;
  logic [31:0] ctl_first_d;
  logic [31:0] ctl_second_q;
  logic [31:0] ctl_second_d;

  // swd link state
  logic [1:0] swd_sync;
  logic swclk_s;
  logic swdio_s;
  logic swclk_prev_q;
  logic swclk_prev_d;
  logic swclk_rise;
  logic [31:0] swd_sample_q;
  logic [31:0] swd_sample_d;
  logic [$clog2(debug_hold_pkg::SWD_IDLE_CYCLES+1)-1:0] idle_cnt_q;
  logic [$clog2(debug_hold_pkg::SWD_IDLE_CYCLES+1)-1:0] idle_cnt_d;
  logic swd_active_q;
  logic swd_active_d;
  logic swd_enable_q;
  logic swd_enable_d;
  logic gpio_d;

  debug_hold_pkg::freeze_s freeze_d;

  localparam logic [$clog2(debug_hold_pkg::SWD_IDLE_CYCLES+1)-1:0] IDLE_LIMIT =
      ($clog2(debug_hold_pkg::SWD_IDLE_CYCLES+1))'(debug_hold_pkg::SWD_IDLE_CYCLES);

  function automatic logic [31:0] reg_read(
    input logic [7:0] ofs,
    input logic [31:0] first,
    input logic [31:0] second,
    input logic [31:0] sample,
    input logic enable,
    input logic active
  );
    logic [31:0] val;
    val = 32'h0000_0000;
    case (ofs)
      debug_hold_pkg::OFS_IDENTITY: val = IDENTITY_VALUE;
      debug_hold_pkg::OFS_CTL_FIRST: val = first;
      debug_hold_pkg::OFS_CTL_SECOND: val = second;
      debug_hold_pkg::OFS_SWD_SAMPLE: val = sample;
      debug_hold_pkg::OFS_SWD_CTRL: begin
        val[debug_hold_pkg::SWD_ENABLE_BIT] = enable;
        val[debug_hold_pkg::SWD_ACTIVE_BIT] = active;
      end
      default: val = 32'h0000_0000;
    endcase
    return val;
  endfunction : reg_read

  // bus address phase and write data phase
  always_comb begin
    acc = hsel && hready && htrans[1];
    in_blk = haddr[31:debug_hold_pkg::BLOCK_LOW_BITS]
        == debug_hold_pkg::BLOCK_BASE_ADDR[31:debug_hold_pkg::BLOCK_LOW_BITS];
    word_acc = (hsize == debug_hold_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);
    wr_pend_d = acc && hwrite && in_blk && word_acc;
    wr_ofs_d = wr_pend_d ? haddr[7:0] : wr_ofs_q;
    hrdata_d = 32'h0000_0000;
    // sub-word and out-of-block reads return zero, with an okay response
    if (acc && !hwrite && in_blk && word_acc) begin
      hrdata_d = reg_read(haddr[7:0], ctl_first_q, ctl_second_q, swd_sample_q,
          swd_enable_q, swd_active_q);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_ofs_q <= wr_ofs_d;
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control registers; identity offset has no storage so writes there vanish
  always_comb begin
    ctl_first_d = ctl_first_q;
    ctl_second_d = ctl_second_q;
    if (wr_pend_q && wr_ofs_q == debug_hold_pkg::OFS_CTL_FIRST) begin
      ctl_first_d = hwdata & debug_hold_pkg::CTL_FIRST_MASK;
    end
    if (wr_pend_q && wr_ofs_q == debug_hold_pkg::OFS_CTL_SECOND) begin
      ctl_second_d = hwdata & debug_hold_pkg::CTL_SECOND_MASK;
    end
  end

  // only power reset clears these, so holds survive a debug-driven system reset
  always_ff @(posedge core_clk or posedge power_rst) begin
    if (power_rst) begin
      ctl_first_q <= debug_hold_pkg::CTL_RESET;
      ctl_second_q <= debug_hold_pkg::CTL_RESET;
    end else begin
      ctl_first_q <= ctl_first_d;
      ctl_second_q <= ctl_second_d;
    end
  end

  // freeze levels; peripherals keep their own count, so release resumes it
  always_comb begin
    freeze_d.timer[0] = core_halted && ctl_first_q[debug_hold_pkg::TIMER0_HOLD_BIT];
    freeze_d.timer[1] = core_halted && ctl_first_q[debug_hold_pkg::TIMER2_HOLD_BIT];
    freeze_d.timer[2] = core_halted && ctl_first_q[debug_hold_pkg::TIMER5_HOLD_BIT];
    freeze_d.timer[3] = core_halted && ctl_first_q[debug_hold_pkg::TIMER13_HOLD_BIT];
    freeze_d.timer[4] = core_halted && ctl_second_q[debug_hold_pkg::TIMER14_HOLD_BIT];
    freeze_d.timer[5] = core_halted && ctl_second_q[debug_hold_pkg::TIMER15_HOLD_BIT];
    freeze_d.timer[6] = core_halted && ctl_second_q[debug_hold_pkg::TIMER16_HOLD_BIT];
    freeze_d.i2c[0] = core_halted && ctl_first_q[debug_hold_pkg::I2C0_HOLD_BIT];
    freeze_d.i2c[1] = core_halted && ctl_first_q[debug_hold_pkg::I2C1_HOLD_BIT];
    freeze_d.rtc = core_halted && ctl_second_q[debug_hold_pkg::RTC_HOLD_BIT];
    freeze_d.window_wdg = core_halted
        && ctl_first_q[debug_hold_pkg::WINDOW_WDG_HOLD_BIT];
    freeze_d.free_wdg = core_halted && ctl_first_q[debug_hold_pkg::FREE_WDG_HOLD_BIT];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      freeze <= '0;
    end else begin
      freeze <= freeze_d;
    end
  end

  // swd link: probe clock is only sampled, never used as a clock
  debug_sync2 #(
    .W(2)
  ) u_swd_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({swclk_pin, swdio_in}),
    .sync_out(swd_sync)
  );

  always_comb begin
    swclk_s = swd_sync[1];
    swdio_s = swd_sync[0];
    swclk_prev_d = swclk_s;
    swclk_rise = swclk_s && !swclk_prev_q;
    swd_sample_d = swd_sample_q;
    idle_cnt_d = idle_cnt_q;
    swd_active_d = swd_active_q;
    swd_enable_d = swd_enable_q;
    if (swclk_rise && swd_enable_q) begin
      swd_sample_d = {swd_sample_q[30:0], swdio_s};
      idle_cnt_d = '0;
      swd_active_d = 1'b1;
    end else if (idle_cnt_q == IDLE_LIMIT) begin
      swd_active_d = 1'b0;
    end else begin
      idle_cnt_d = idle_cnt_q + 1'b1;
    end
    if (wr_pend_q && wr_ofs_q == debug_hold_pkg::OFS_SWD_CTRL) begin
      swd_enable_d = hwdata[debug_hold_pkg::SWD_ENABLE_BIT];
    end
    gpio_d = !swd_enable_d;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      swclk_prev_q <= 1'b0;
      swd_sample_q <= 32'h0000_0000;
      idle_cnt_q <= '0;
      swd_active_q <= 1'b0;
      swd_enable_q <= debug_hold_pkg::SWD_ENABLE_RESET;
      swd_pins_to_gpio <= 1'b0;
      swdio_out <= 1'b0;
      swdio_oe <= 1'b0;
    end else begin
      swclk_prev_q <= swclk_prev_d;
      swd_sample_q <= swd_sample_d;
      idle_cnt_q <= idle_cnt_d;
      swd_active_q <= swd_active_d;
      swd_enable_q <= swd_enable_d;
      swd_pins_to_gpio <= gpio_d;
      // the data line is answered by the debug port proper; this unit only listens
      swdio_out <= 1'b0;
      swdio_oe <= 1'b0;
    end
  end

  debug_pwr_keep u_pwr_keep (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pwr_req(pwr_req),
    .standby_exit(standby_exit),
    .sleep_debug_keep(ctl_first_q[debug_hold_pkg::SLEEP_KEEP_BIT]),
    .deepsleep_debug_keep(ctl_first_q[debug_hold_pkg::DEEPSLEEP_KEEP_BIT]),
    .standby_debug_keep(ctl_first_q[debug_hold_pkg::STANDBY_KEEP_BIT]),
    .bus_clk_on_osc(bus_clk_on_osc),
    .sys_clk_on_osc(sys_clk_on_osc),
    .cpu_bus_clk_keep(cpu_bus_clk_keep),
    .sys_reset_req(sys_reset_req)
  );

  chk_timer_freeze_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    (core_halted && ctl_first_q[debug_hold_pkg::TIMER0_HOLD_BIT]
     && ctl_second_q[debug_hold_pkg::TIMER16_HOLD_BIT])
    |=> (freeze.timer[0] && freeze.timer[6]))
    else $error("halted timer not frozen");

  chk_i2c_timeout_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (core_halted && ctl_first_q[debug_hold_pkg::I2C1_HOLD_BIT]) |=> freeze.i2c[1])
    else $error("halted i2c timeout not held");

  chk_rtc_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    freeze.rtc |-> $past(core_halted) && $past(ctl_second_q[debug_hold_pkg::RTC_HOLD_BIT]))
    else $error("rtc frozen without its cause");

  chk_wdg_clock_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    (core_halted && ctl_first_q[debug_hold_pkg::FREE_WDG_HOLD_BIT]
     && !ctl_first_q[debug_hold_pkg::WINDOW_WDG_HOLD_BIT])
    |=> (freeze.free_wdg && !freeze.window_wdg))
    else $error("watchdog gates not per their hold bits");

  chk_freeze_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    !core_halted |=> (freeze == '0))
    else $error("freeze persists after the core runs");

  chk_identity_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (acc && !hwrite && word_acc && haddr == debug_hold_pkg::BLOCK_BASE_ADDR)
    |=> (hrdata == IDENTITY_VALUE && hreadyout && !hresp))
    else $error("identity read wrong");

  chk_outside_block: assert property (@(posedge core_clk) disable iff (sys_rst)
    (acc && !hwrite && !in_blk) |=> (hrdata == 32'h0000_0000))
    else $error("read outside block returned data");

  chk_ctl_write: assert property (@(posedge core_clk) disable iff (power_rst)
    (wr_pend_q && wr_ofs_q == debug_hold_pkg::OFS_CTL_FIRST)
    |=> (ctl_first_q == ($past(hwdata) & debug_hold_pkg::CTL_FIRST_MASK)))
    else $error("first control register write not stored");

  chk_identity_nowrite: assert property (@(posedge core_clk) disable iff (power_rst)
    (wr_pend_q && wr_ofs_q == debug_hold_pkg::OFS_IDENTITY)
    |=> ($stable(ctl_first_q) && $stable(ctl_second_q)))
    else $error("identity write disturbed other registers");

  chk_gpio_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_pend_q && wr_ofs_q == debug_hold_pkg::OFS_SWD_CTRL && !hwdata[0])
    |=> swd_pins_to_gpio)
    else $error("swd pins not released");

endmodule : debug_hold_control

// >>> swd_probe_model.sv
// serial debug probe model: drives the link clock and the data line of the debug port
// assumes the bench resolves the data wire from both enables; the wire is pulled up
`timescale 1ns/1ns
module swd_probe_model (
  output logic swclk,
  output logic dio_out,
  output logic dio_oe
);
  initial begin
    swclk = 1'b0;
    dio_out = 1'b0;
    dio_oe = 1'b0;
  end

  // the clock stands low between frames; the data changes only while the clock is low
  // gap idles the link before the frame; the small offset keeps pin edges off core_clk edges
  task automatic send(input logic [31:0] w, input int gap);
    #(2 + gap);
    for (int i = 31; i >= 0; i--) begin
      dio_oe = 1'b1;
      dio_out = w[i];
      #80 swclk = 1'b1;
      #80 swclk = 1'b0;
    end
    dio_oe = 1'b0;
  endtask : send
endmodule : swd_probe_model

// >>> testbench.sv
// self-checking bench of the debug hold unit: ahb-lite master, probe model, status checks
// assumes zero-wait registered bus answers and one-cycle registered status outputs
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  localparam logic [31:0] ID_VAL = 32'h0000_7e11; // arbitrary identity value
  localparam logic [31:0] B = debug_hold_pkg::BLOCK_BASE_ADDR;
  localparam logic [7:0] CF = debug_hold_pkg::OFS_CTL_FIRST;
  localparam logic [7:0] CS = debug_hold_pkg::OFS_CTL_SECOND;
  localparam logic [7:0] SC = debug_hold_pkg::OFS_SWD_CTRL;
  localparam logic [7:0] SS = debug_hold_pkg::OFS_SWD_SAMPLE;
  logic core_clk, sys_rst, power_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, stat_w, e_w, f, s, w;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic core_halted, standby_exit, swclk, p_dio, p_oe, dio_wire, rd_dp, stat_look;
  logic swdio_out, swdio_oe, swd_pins_to_gpio, bus_clk_on_osc, sys_clk_on_osc;
  logic cpu_bus_clk_keep, sys_reset_req;
  debug_hold_pkg::pwr_req_s pwr_req;
  debug_hold_pkg::freeze_s freeze;
  logic [31:0] exp_q[$];
  int miscompares, checked;

  assign hready = hreadyout;
  // pull-up on the data line whenever nobody drives it
  assign dio_wire = swdio_oe ? swdio_out : (p_oe ? p_dio : 1'b1);
  assign stat_w = {12'h0, hresp, swdio_out, freeze, bus_clk_on_osc, sys_clk_on_osc,
    cpu_bus_clk_keep,
    sys_reset_req, swd_pins_to_gpio, swdio_oe};

  debug_hold_control #(.IDENTITY_VALUE(ID_VAL)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .power_rst(power_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .core_halted(core_halted), .pwr_req(pwr_req), .standby_exit(standby_exit),
    .swclk_pin(swclk), .swdio_in(dio_wire), .swdio_out(swdio_out), .swdio_oe(swdio_oe),
    .swd_pins_to_gpio(swd_pins_to_gpio), .freeze(freeze), .bus_clk_on_osc(bus_clk_on_osc),
    .sys_clk_on_osc(sys_clk_on_osc), .cpu_bus_clk_keep(cpu_bus_clk_keep),
    .sys_reset_req(sys_reset_req));

  swd_probe_model u_probe (.swclk(swclk), .dio_out(p_dio), .dio_oe(p_oe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // watcher: takes the oldest note whenever read data or a status sample is due
  always @(posedge core_clk) begin
    if (rd_dp && hreadyout) begin
      e_w = exp_q.pop_front();
      `CHK("hrdata", e_w, hrdata)
    end
    if (stat_look) begin
      e_w = exp_q.pop_front();
      `CHK("status", e_w, stat_w)
    end
    rd_dp <= hsel & hready & htrans[1] & !hwrite;
  end

  task automatic summarize;
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    summarize();
  end

  task automatic wait_rdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (hready === 1'b1) break;
    end
    if (i == 50) begin
      miscompares++;
      summarize();
    end
  endtask : wait_rdy

  // for reads d is the expected word, for writes the data
  task automatic bus(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] d);
    if (!wr) exp_q.push_back(d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    wait_rdy();
  endtask : bus

  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    bus(1'b0, B + 32'(o), debug_hold_pkg::HSIZE_WORD, e);
  endtask : rd

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    bus(1'b1, B + 32'(o), debug_hold_pkg::HSIZE_WORD, d);
  endtask : wr

  task automatic look(input logic [31:0] e);
    @(posedge core_clk);
    exp_q.push_back(e);
    stat_look <= 1'b1;
    @(posedge core_clk);
    stat_look <= 1'b0;
  endtask : look

  function automatic logic [31:0] st(input logic [11:0] fz, input logic osc,
                                     input logic kp, input logic rq, input logic gp);
    st = {12'h0, 2'h0, fz, osc, osc, kp, rq, gp, 1'b0};
  endfunction : st

  function automatic logic [11:0] fz_of(input logic [31:0] a, input logic [31:0] b);
    fz_of = {b[debug_hold_pkg::TIMER16_HOLD_BIT], b[debug_hold_pkg::TIMER15_HOLD_BIT],
      b[debug_hold_pkg::TIMER14_HOLD_BIT], a[debug_hold_pkg::TIMER13_HOLD_BIT],
      a[debug_hold_pkg::TIMER5_HOLD_BIT], a[debug_hold_pkg::TIMER2_HOLD_BIT],
      a[debug_hold_pkg::TIMER0_HOLD_BIT], a[debug_hold_pkg::I2C1_HOLD_BIT],
      a[debug_hold_pkg::I2C0_HOLD_BIT], b[debug_hold_pkg::RTC_HOLD_BIT],
      a[debug_hold_pkg::WINDOW_WDG_HOLD_BIT], a[debug_hold_pkg::FREE_WDG_HOLD_BIT]};
  endfunction : fz_of

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {core_halted, standby_exit, rd_dp, stat_look} = '0;
    pwr_req = '0;
    sys_rst = 1'b1;
    power_rst = 1'b1;
    void'($urandom(48));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    power_rst <= 1'b0;
    look(st(12'h000, 1'b0, 1'b0, 1'b0, 1'b0));
    rd(debug_hold_pkg::OFS_IDENTITY, ID_VAL);
    rd(CF, 32'h0000_0000);
    rd(CS, 32'h0000_0000);
    rd(SC, 32'h0000_0001);
    wr(debug_hold_pkg::OFS_IDENTITY, ~ID_VAL);
    rd(debug_hold_pkg::OFS_IDENTITY, ID_VAL);
    bus(1'b0, B + 32'h0000_0014, debug_hold_pkg::HSIZE_WORD, 32'h0000_0000);
    bus(1'b1, B + 32'h0000_0104, debug_hold_pkg::HSIZE_WORD, 32'hffff_ffff);
    bus(1'b0, B + 32'h0000_0104, debug_hold_pkg::HSIZE_WORD, 32'h0000_0000);
    rd(CF, 32'h0000_0000);
    f = $urandom();
    s = $urandom();
    wr(CF, f);
    wr(CS, s);
    rd(CF, f & debug_hold_pkg::CTL_FIRST_MASK);
    rd(CS, s & debug_hold_pkg::CTL_SECOND_MASK);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(CF, f & debug_hold_pkg::CTL_FIRST_MASK);
    power_rst <= 1'b1;
    @(posedge core_clk);
    power_rst <= 1'b0;
    @(posedge core_clk);
    rd(CS, 32'h0000_0000);
    // hold bits: all ones first, then random mixes; halted, partly cleared, resumed
    for (int k = 0; k < 6; k++) begin
      // later passes hold the free watchdog alone so the gates are told apart
      f = (k == 0) ? 32'hffff_fff8 : ($urandom() & 32'hffff_fdf8) | 32'h0000_0100;
      s = (k == 0) ? 32'hffff_ffff : $urandom();
      wr(CF, f);
      wr(CS, s);
      look(st(12'h000, 1'b0, 1'b0, 1'b0, 1'b0));
      core_halted <= 1'b1;
      look(st(fz_of(f, s), 1'b0, 1'b0, 1'b0, 1'b0));
      wr(CF, 32'h0000_0000);
      look(st(fz_of(32'h0000_0000, s), 1'b0, 1'b0, 1'b0, 1'b0));
      core_halted <= 1'b0;
      look(st(12'h000, 1'b0, 1'b0, 1'b0, 1'b0));
    end
    // every low-power mode with and without its keep bit
    for (int kp = 0; kp < 2; kp++) begin
      wr(CF, (kp == 1) ? 32'h0000_0007 : 32'h0000_0000);
      for (int m = 0; m < 3; m++) begin
        pwr_req <= 3'h4 >> m;
        look(st(12'h000, kp == 1 && m > 0, kp == 1 && m == 0, 1'b0, 1'b0));
        pwr_req <= 3'h0;
        if (m == 2) begin
          look(st(12'h000, kp == 1, 1'b0, 1'b0, 1'b0));
          standby_exit <= 1'b1;
          @(posedge core_clk);
          standby_exit <= 1'b0;
          exp_q.push_back(st(12'h000, 1'b0, 1'b0, kp == 1, 1'b0));
          stat_look <= 1'b1;
          @(posedge core_clk);
          stat_look <= 1'b0;
        end
        else look(st(12'h000, 1'b0, 1'b0, 1'b0, 1'b0));
      end
    end
    w = $urandom();
    u_probe.send(w, 0);
    repeat (8) @(posedge core_clk);
    rd(SS, w);
    rd(SC, 32'h0000_0003);
    repeat (1010) @(posedge core_clk);
    rd(SC, 32'h0000_0001);
    w = $urandom();
    u_probe.send(w, 200);
    repeat (8) @(posedge core_clk);
    rd(SS, w);
    wr(SC, 32'h0000_0000);
    look(st(12'h000, 1'b0, 1'b0, 1'b0, 1'b1));
    u_probe.send(~w, 0);
    repeat (8) @(posedge core_clk);
    rd(SS, w);
    // let the watcher take the last answer before the verdict
    repeat (2) @(posedge core_clk);
    summarize();
  end
endmodule : testbench
